// *** sbcint_top.sv ***
module sbcint_top #(
    parameter int TO_CYC = sbcint_pkg::INT_TO_CYC
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rstn,
    // Wake sources, asynchronous levels
    input  wire logic        wake_from_can,
    input  wire logic        wake_from_lin,
    input  wire logic        wake_from_pin,
    input  wire logic        periodic_wake,
    // Temperature and bus faults, asynchronous levels
    input  wire logic        main_rail_overtemp_prewarn,
    input  wire logic        aux_rail_a_overtemp,
    input  wire logic        bus_transceiver_overtemp,
    input  wire logic        can_bus_failure,
    input  wire logic        lin_bus_failure,
    // Rail faults, asynchronous levels
    input  wire logic        aux_rail_a_undervoltage,
    input  wire logic        aux_rail_b_undervoltage,
    input  wire logic        aux_rail_b_overcurrent,
    // Chip failures, asynchronous levels
    input  wire logic        spi_frame_corrupt,
    input  wire logic        reset_event,
    input  wire logic        bad_watchdog_config,
    // Rail and mode control, same clock
    input  wire logic        aux_rail_a_on,
    input  wire logic        aux_rail_b_on,
    input  wire logic        aux_rail_a_switch_on,
    input  wire logic        aux_rail_b_switch_on,
    input  wire logic        sw_dev_mode,
    input  wire logic        int_mode_active,
    input  wire logic        restart_done,
    // Mask control, same clock
    input  wire logic        mask_wr,
    input  wire logic [14:0] mask_wdata,
    output logic      [14:0] int_mask,
    // Status read from the serial slave, same clock
    input  wire logic        spi_cmd_valid,
    input  wire logic [2:0]  spi_cmd,
    input  wire logic [2:0]  spi_addr,
    output logic      [7:0]  spi_rdata,
    output logic             spi_rdata_valid,
    // Interrupt pin, open drain
    input  wire logic        int_pin_in,
    output logic             int_pin_out,
    output logic             int_pin_oe,
    // Initialisation
    input  wire logic        reset_output_n,
    output logic             cfg_group_2_4
);
    logic [16:0] sync_d;
    logic [16:0] sync_q;
    logic [14:0] src_s;
    logic        pin_s;
    logic        rstout_s;
    logic        rstout_q;
    logic        cfg_sample;
    logic [14:0] gate;
    logic [14:0] g;
    logic [14:0] g_q;
    logic [14:0] set_vec;
    logic [14:0] irq_vec;
    logic [14:0] lat;
    logic [14:0] status;
    logic [14:0] clr;
    logic        summary;
    logic        rd_go;
    logic        rel;
    logic        irq_go;
    logic        pend;

    sbcint_pulse_if pif ();

    function automatic logic [14:0] reg_bits(input logic [2:0] addr);
        logic [14:0] r;
        r = '0;
        if (addr == sbcint_pkg::ADDR_WAKE) begin
            r = sbcint_pkg::REG_WAKE_BITS;
        end else if (addr == sbcint_pkg::ADDR_FAIL_A) begin
            r = sbcint_pkg::REG_FA_BITS;
        end else if (addr == sbcint_pkg::ADDR_FAIL_B) begin
            r = sbcint_pkg::REG_FB_BITS;
        end
        return r;
    endfunction

    function automatic logic [7:0] rd_word(input logic [2:0] addr,
                                           input logic [14:0] st,
                                           input logic sum);
        logic [7:0] w;
        w = '0;
        if (addr == sbcint_pkg::ADDR_WAKE) begin
            w = {sum, 3'h0, st[sbcint_pkg::W_HI:sbcint_pkg::W_LO]};
        end else if (addr == sbcint_pkg::ADDR_FAIL_A) begin
            w = {3'h0, st[sbcint_pkg::FA_HI:sbcint_pkg::FA_LO]};
        end else if (addr == sbcint_pkg::ADDR_FAIL_B) begin
            w = {2'h0, st[sbcint_pkg::FB_HI:sbcint_pkg::FB_LO]};
        end
        return w;
    endfunction

    assign sync_d = {reset_output_n, int_pin_in,
                     bad_watchdog_config, reset_event, spi_frame_corrupt,
                     aux_rail_b_overcurrent, aux_rail_b_undervoltage,
                     aux_rail_a_undervoltage,
                     lin_bus_failure, can_bus_failure, bus_transceiver_overtemp,
                     aux_rail_a_overtemp, main_rail_overtemp_prewarn,
                     periodic_wake, wake_from_pin, wake_from_lin, wake_from_can};

    sbcint_sync #(
        .W (17)
    ) u_sync (
        .clk  (clk),
        .rstn (rstn),
        .d    (sync_d),
        .q    (sync_q)
    );

    assign src_s    = sync_q[14:0];
    assign pin_s    = sync_q[15];
    assign rstout_s = sync_q[16];

    always_comb begin
        gate                    = '1;
        gate[sbcint_pkg::R_UVA] = aux_rail_a_on;
        gate[sbcint_pkg::R_UVB] = aux_rail_b_on;
        gate[sbcint_pkg::R_OCB] = aux_rail_b_on;
        gate[sbcint_pkg::F_RST] = sw_dev_mode;
    end

    assign g = src_s & gate;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            g_q <= '0;
        end else begin
            g_q <= g;
        end
    end

    always_comb begin
        set_vec                    = g & ~g_q;
        set_vec[sbcint_pkg::R_UVA] = set_vec[sbcint_pkg::R_UVA] | aux_rail_a_switch_on;
        set_vec[sbcint_pkg::R_UVB] = set_vec[sbcint_pkg::R_UVB] | aux_rail_b_switch_on;
    end

    assign irq_vec = set_vec | (~g & g_q & gate & sbcint_pkg::UV_BITS);

    assign rd_go = spi_cmd_valid && (spi_cmd == sbcint_pkg::CMD_READ_ONLY);
    assign rel   = rd_go && (spi_addr == sbcint_pkg::ADDR_WAKE);

    assign clr = rd_go ? reg_bits(spi_addr) : '0;

    // event bits, set wins over clear
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            lat <= '0;
        end else begin
            lat <= (lat & ~clr) | set_vec;
        end
    end

    assign status = lat | (g & sbcint_pkg::STATE_BITS);

    assign summary = |(status & (sbcint_pkg::REG_FA_BITS | sbcint_pkg::REG_FB_BITS));

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            int_mask <= sbcint_pkg::MASK_RST;
        end else if (restart_done) begin
            int_mask <= sbcint_pkg::MASK_RST;
        end else if (mask_wr) begin
            int_mask <= mask_wdata;
        end
    end

    assign irq_go = int_mode_active && ((irq_vec & int_mask) != '0);

    // events in the gap wait here
    // read absorbs events of the current pulse
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pend <= 1'b0;
        end else if (irq_go) begin
            pend <= 1'b1;
        end else if (pif.accept || (rel && pif.int_low)) begin
            pend <= 1'b0;
        end
    end

    // pin only in normal and stop mode, never during init
    assign pif.request  = pend;
    assign pif.read_rel = rel;
    assign pif.enable   = int_mode_active && rstout_s;

    sbcint_pulse_ctrl #(
        .TO_CYC (TO_CYC)
    ) u_pulse (
        .clk  (clk),
        .rstn (rstn),
        .pif  (pif)
    );

    assign int_pin_oe = pif.int_low;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            int_pin_out <= 1'b0;
        end else begin
            int_pin_out <= 1'b0;
        end
    end

    // Status read: data shows the value before this read clears it
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            spi_rdata       <= '0;
            spi_rdata_valid <= 1'b0;
        end else begin
            spi_rdata_valid <= spi_cmd_valid;
            if (spi_cmd_valid) begin
                spi_rdata <= rd_word(spi_addr, status, summary);
            end
        end
    end

    // pin read while reset output low
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rstout_q   <= 1'b0;
            cfg_sample <= 1'b0;
        end else begin
            rstout_q <= rstout_s;
            if (!rstout_s) begin
                cfg_sample <= pin_s;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cfg_group_2_4 <= 1'b0;
        end else if (rstout_s && !rstout_q) begin
            cfg_group_2_4 <= cfg_sample;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    property p_set_latched;
        (set_vec != '0) |=> ((lat & $past(set_vec)) == $past(set_vec));
    endproperty
    a_set_latched: assert property (p_set_latched) else $error("event lost");

    property p_masked_quiet;
        (!pend && ((irq_vec & int_mask) == '0)) |=> !pend;
    endproperty
    a_masked_quiet: assert property (p_masked_quiet) else $error("masked event pends");

    property p_summary;
        (spi_cmd_valid && spi_addr == sbcint_pkg::ADDR_WAKE)
            |=> (spi_rdata[sbcint_pkg::SUM_BIT] == $past(summary));
    endproperty
    a_summary: assert property (p_summary) else $error("summary bit wrong");

    property p_wake_clear;
        (rel && ((set_vec & sbcint_pkg::REG_WAKE_BITS) == '0))
            |=> ((lat & sbcint_pkg::REG_WAKE_BITS) == '0);
    endproperty
    a_wake_clear: assert property (p_wake_clear) else $error("wake bit not cleared");

    property p_uv_off;
        (!aux_rail_a_on && !aux_rail_a_switch_on) |-> !irq_vec[sbcint_pkg::R_UVA];
    endproperty
    a_uv_off: assert property (p_uv_off) else $error("uv irq from off rail");

    property p_reset_dev;
        !sw_dev_mode |-> !set_vec[sbcint_pkg::F_RST];
    endproperty
    a_reset_dev: assert property (p_reset_dev) else $error("reset source outside dev");

    property p_cfg_hold;
        (rstout_s && rstout_q) |=> $stable(cfg_group_2_4);
    endproperty
    a_cfg_hold: assert property (p_cfg_hold) else $error("config changed");

    sequence s_stored;
        irq_go && !pif.accept;
    endsequence

    sequence s_waiting;
        pend && !pif.accept && !rel;
    endsequence

    property p_gap_pend;
        s_stored ##1 s_waiting |=> pend;
    endproperty
    a_gap_pend: assert property (p_gap_pend) else $error("stored event dropped");

    property p_restart_mask;
        restart_done |=> (int_mask == sbcint_pkg::MASK_RST);
    endproperty
    a_restart_mask: assert property (p_restart_mask) else $error("mask not restored");
endmodule

// *** sbcint_pkg.sv ***
package sbcint_pkg;
    // Oscillator rate and interrupt timing
    localparam int CLK_MHZ     = 125;
    localparam int INT_TO_US   = 6000;
    localparam int INT_TO_CYC  = INT_TO_US * CLK_MHZ;
    localparam int INT_MIN_US  = 10;
    localparam int INT_MIN_CYC = INT_MIN_US * CLK_MHZ;
    localparam int TMR_W       = 20;

    // Command and register addresses
    localparam logic [2:0] CMD_READ_ONLY = 3'h7;
    localparam logic [2:0] ADDR_WAKE     = 3'h0;
    localparam logic [2:0] ADDR_FAIL_A   = 3'h1;
    localparam logic [2:0] ADDR_FAIL_B   = 3'h2;

    // Source vector positions
    localparam int SRC_N   = 15;
    localparam int W_LO    = 0;
    localparam int W_HI    = 3;
    localparam int FA_LO   = 4;
    localparam int FA_HI   = 8;
    localparam int FB_LO   = 9;
    localparam int FB_HI   = 14;
    localparam int R_UVA   = 9;
    localparam int R_UVB   = 10;
    localparam int R_OCB   = 11;
    localparam int F_RST   = 13;
    localparam int SUM_BIT = 7;
    localparam int RD_W    = 8;

    // Bit groups and reset values
    localparam logic [14:0] STATE_BITS    = 15'h0FF0;
    localparam logic [14:0] UV_BITS       = 15'h0600;
    localparam logic [14:0] REG_WAKE_BITS = 15'h000F;
    localparam logic [14:0] REG_FA_BITS   = 15'h01F0;
    localparam logic [14:0] REG_FB_BITS   = 15'h7E00;
    localparam logic [14:0] MASK_RST      = 15'h7FFF;
endpackage

// *** sbcint_pulse_if.sv ***
interface sbcint_pulse_if;
    logic request;
    logic read_rel;
    logic enable;
    logic accept;
    logic int_low;

    modport ctrl (
        input  request,
        input  read_rel,
        input  enable,
        output accept,
        output int_low
    );
    modport user (
        output request,
        output read_rel,
        output enable,
        input  accept,
        input  int_low
    );
endinterface

// *** sbcint_sync.sv ***
module sbcint_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rstn,
    // Levels in and out
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            meta <= '0;
            q    <= '0;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule

// *** sbcint_pulse_ctrl.sv ***
module sbcint_pulse_ctrl #(
    parameter int TO_CYC = sbcint_pkg::INT_TO_CYC
) (
    // Clock and reset
    input  wire logic     clk,
    input  wire logic     rstn,
    // Pulse handshake
    sbcint_pulse_if.ctrl  pif
);
    typedef enum logic [1:0] {st_idle, st_low, st_gap} sbcint_pstate_e;

    localparam logic [sbcint_pkg::TMR_W-1:0] TO_LAST  = sbcint_pkg::TMR_W'(TO_CYC - 1);
    localparam logic [sbcint_pkg::TMR_W-1:0] MIN_LAST =
        sbcint_pkg::TMR_W'(sbcint_pkg::INT_MIN_CYC - 1);

    sbcint_pstate_e                  state;
    logic [sbcint_pkg::TMR_W-1:0]    tmr;
    logic                            rel_seen;
    logic [sbcint_pkg::TMR_W-1:0]    run_q;
    logic [sbcint_pkg::TMR_W-1:0]    gap_q;

    assign pif.accept = (state == st_idle) && pif.request && pif.enable;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state       <= st_idle;
            tmr         <= '0;
            pif.int_low <= 1'b0;
        end else begin
            case (state)
                st_idle: begin
                    if (pif.accept) begin
                        state       <= st_low;
                        tmr         <= '0;
                        pif.int_low <= 1'b1;
                    end
                end
                st_low: begin
                    if (tmr >= MIN_LAST && (tmr >= TO_LAST || rel_seen || pif.read_rel)) begin
                        state       <= st_gap;
                        tmr         <= '0;
                        pif.int_low <= 1'b0;
                    end else begin
                        tmr <= tmr + 1'b1;
                    end
                end
                st_gap: begin
                    if (tmr >= TO_LAST) begin
                        state <= st_idle;
                    end else begin
                        tmr <= tmr + 1'b1;
                    end
                end
                default: begin
                    state <= st_idle;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rel_seen <= 1'b0;
        end else if (state != st_low) begin
            rel_seen <= 1'b0;
        end else if (pif.read_rel) begin
            rel_seen <= 1'b1;
        end
    end

    // Lengths of the current low and high stretches, for checking only
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            run_q <= '0;
            gap_q <= '1;
        end else begin
            run_q <= pif.int_low ? run_q + 1'b1 : '0;
            gap_q <= pif.int_low ? '0 : ((&gap_q) ? gap_q : gap_q + 1'b1);
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    property p_min_width;
        $fell(pif.int_low) |-> (run_q >= sbcint_pkg::INT_MIN_CYC);
    endproperty
    a_min_width: assert property (p_min_width) else $error("low pulse too short");

    property p_timeout;
        pif.int_low |-> (run_q < TO_CYC || run_q < sbcint_pkg::INT_MIN_CYC);
    endproperty
    a_timeout: assert property (p_timeout) else $error("low beyond time-out");

    property p_gap;
        $rose(pif.int_low) |-> (gap_q >= TO_CYC);
    endproperty
    a_gap: assert property (p_gap) else $error("pulses too close");

    property p_release;
        (pif.read_rel && pif.int_low && run_q >= MIN_LAST) |=> !pif.int_low;
    endproperty
    a_release: assert property (p_release) else $error("read did not release");

    property p_start_enabled;
        $rose(pif.int_low) |-> $past(pif.enable) && $past(pif.request);
    endproperty
    a_start_enabled: assert property (p_start_enabled) else $error("pulse while idle");
endmodule

// *** sbcint_host_model.sv ***
module sbcint_host_model (
    // Clock
    input  wire logic       clk,
    // Interrupt pin
    input  wire logic       int_pin_oe,
    input  wire logic       int_pin_out,
    input  wire logic       cfg_low,
    output logic            int_pin_in,
    // Status read port
    input  wire logic [7:0] spi_rdata,
    input  wire logic       spi_rdata_valid,
    output logic            spi_cmd_valid,
    output logic [2:0]      spi_cmd,
    output logic [2:0]      spi_addr
);
    timeunit 1ns;
    timeprecision 1ps;

    // Pull-up on the pin; the host may hold it low during initialisation
    assign int_pin_in = (int_pin_oe ? int_pin_out : 1'b1) & ~cfg_low;

    initial begin
        spi_cmd_valid = 1'b0;
        spi_cmd = 3'h0;
        spi_addr = 3'h0;
    end

    task automatic xfer(input logic [2:0] c, input logic [2:0] a, output logic [7:0] d);
        int n;
        n = 0;
        @(negedge clk);
        spi_cmd_valid = 1'b1;
        spi_cmd = c;
        spi_addr = a;
        @(negedge clk);
        spi_cmd_valid = 1'b0;
        // Released fields show the inverse so stale values never pass
        spi_cmd = ~c;
        spi_addr = ~a;
        while (spi_rdata_valid !== 1'b1 && n < 4) begin
            @(negedge clk);
            n++;
        end
        d = (spi_rdata_valid === 1'b1) ? spi_rdata : 8'hFF;
    endtask
endmodule

// *** sbc_interrupt_output_logic_tb_top.sv ***
module sbc_interrupt_output_logic_tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int TO = 2000;
    localparam int LIM = 80000;
    logic        clk, rstn, ra_on, ra_sw, dev, act, rdone, mwr, cv, rdv;
    logic        pin, pout, oe, ron, cfg, cfg_low, rb_on, rb_sw;
    logic [14:0] src, mwd, msk;
    logic [2:0]  cmd, adr;
    logic [7:0]  rd;
    int          errors, samples_checked, cyc, rises;

    sbcint_top #(.TO_CYC(TO)) uut (
        .clk, .rstn, .wake_from_can(src[0]), .wake_from_lin(src[1]),
        .wake_from_pin(src[2]), .periodic_wake(src[3]),
        .main_rail_overtemp_prewarn(src[4]), .aux_rail_a_overtemp(src[5]),
        .bus_transceiver_overtemp(src[6]), .can_bus_failure(src[7]),
        .lin_bus_failure(src[8]), .aux_rail_a_undervoltage(src[9]),
        .aux_rail_b_undervoltage(src[10]), .aux_rail_b_overcurrent(src[11]),
        .spi_frame_corrupt(src[12]), .reset_event(src[13]),
        .bad_watchdog_config(src[14]), .aux_rail_a_on(ra_on), .aux_rail_b_on(rb_on),
        .aux_rail_a_switch_on(ra_sw), .aux_rail_b_switch_on(rb_sw),
        .sw_dev_mode(dev), .int_mode_active(act), .restart_done(rdone),
        .mask_wr(mwr), .mask_wdata(mwd), .int_mask(msk), .spi_cmd_valid(cv),
        .spi_cmd(cmd), .spi_addr(adr), .spi_rdata(rd), .spi_rdata_valid(rdv),
        .int_pin_in(pin), .int_pin_out(pout), .int_pin_oe(oe),
        .reset_output_n(ron), .cfg_group_2_4(cfg)
    );

    sbcint_host_model host (
        .clk, .int_pin_oe(oe), .int_pin_out(pout), .cfg_low, .int_pin_in(pin),
        .spi_rdata(rd), .spi_rdata_valid(rdv), .spi_cmd_valid(cv),
        .spi_cmd(cmd), .spi_addr(adr)
    );

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    always @(posedge oe) rises++;

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == LIM) begin
            errors++;
            give_verdict();
        end
    end

    task automatic give_verdict;
        if (errors == 0 && samples_checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input string w, input logic [14:0] e, input logic [14:0] g);
        samples_checked++;
        if (g !== e) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", w, e, g);
        end
    endtask

    task automatic chk_in(input string w, input int lo, input int hi, input int g);
        samples_checked++;
        if (g < lo || g > hi) begin
            errors++;
            $display("CHECK FAILED %s expected %0d..%0d seen %0d", w, lo, hi, g);
        end
    endtask

    task automatic wait_oe(input logic l, input int lim);
        int n;
        n = 0;
        while (oe !== l && n < lim) begin
            @(negedge clk);
            n++;
        end
    endtask

    task automatic up(output int t);
        wait_oe(1'b1, 8);
        chk("pin active", 15'h1, 15'(oe));
        chk("pin drive level", 15'h0, 15'(pout));
        t = cyc;
    endtask

    task automatic rdc(input logic [2:0] c, input logic [2:0] a, input logic [7:0] e);
        logic [7:0] d;
        host.xfer(c, a, d);
        chk("read data", 15'(e), 15'(d));
    endtask

    task automatic drain;
        repeat (2) begin
            rdc(3'h7, 3'h0, 8'h00);
            wait_oe(1'b0, TO + 4);
            repeat (TO + 8) @(negedge clk);
        end
    endtask

    task automatic t_cfg;
        chk("mask reset", 15'h7FFF, msk);
        chk("pin idle", 15'h0, 15'(oe));
        repeat (4) @(negedge clk);
        ron = 1'b1;
        repeat (6) @(negedge clk);
        chk("config", 15'h1, 15'(cfg));
        ron = 1'b0;
        cfg_low = 1'b1;
        repeat (6) @(negedge clk);
        ron = 1'b1;
        repeat (6) @(negedge clk);
        cfg_low = 1'b0;
        repeat (6) @(negedge clk);
        chk("config held", 15'h0, 15'(cfg));
    endtask

    task automatic t_wake;
        int t;
        src[0] = 1'b1;
        up(t);
        rdc(3'h7, 3'h0, 8'h01);
        wait_oe(1'b0, TO + 4);
        chk_in("short pulse", 1250, 1252, cyc - t);
        src[0] = 1'b0;
        rdc(3'h7, 3'h0, 8'h00);
        repeat (TO + 8) @(negedge clk);
    endtask

    task automatic t_timeout;
        int t;
        src[1] = 1'b1;
        up(t);
        wait_oe(1'b0, TO + 4);
        chk_in("time-out", TO - 2, TO, cyc - t);
        src[2] = 1'b1;
        t = cyc;
        wait_oe(1'b1, TO + 12);
        chk_in("gap", TO + 1, TO + 8, cyc - t);
        rdc(3'h7, 3'h0, 8'h06);
        src[2:1] = 2'b00;
        drain();
    endtask

    task automatic t_multi;
        int r;
        r = rises;
        src = 15'h5DF0;
        repeat (40) @(negedge clk);
        chk_in("pulse count", 1, 1, rises - r);
        rdc(3'h7, 3'h0, 8'h80);
        rdc(3'h7, 3'h1, 8'h1F);
        // Let the source change pass the synchroniser before reading
        src = 15'h0400;
        repeat (4) @(negedge clk);
        rdc(3'h7, 3'h1, 8'h00);
        rdc(3'h7, 3'h0, 8'h80);
        rdc(3'h2, 3'h2, 8'h2E);
        rdc(3'h7, 3'h2, 8'h2E);
        rdc(3'h7, 3'h2, 8'h02);
        src = 15'h0000;
        repeat (4) @(negedge clk);
        rdc(3'h7, 3'h2, 8'h00);
        rdc(3'h7, 3'h0, 8'h00);
        drain();
    endtask

    task automatic t_mask;
        int r;
        @(negedge clk);
        mwr = 1'b1;
        mwd = 15'h7FFE;
        @(negedge clk);
        mwr = 1'b0;
        chk("mask write", 15'h7FFE, msk);
        r = rises;
        src[0] = 1'b1;
        repeat (20) @(negedge clk);
        chk_in("masked", r, r, rises);
        rdc(3'h7, 3'h0, 8'h01);
        rdone = 1'b1;
        @(negedge clk);
        rdone = 1'b0;
        chk("mask restart", 15'h7FFF, msk);
        act = 1'b0;
        src[3] = 1'b1;
        repeat (20) @(negedge clk);
        act = 1'b1;
        src[13] = 1'b1;
        repeat (20) @(negedge clk);
        chk_in("mode and dev off", r, r, rises);
        // Old reset level must clear the synchroniser before the mode opens
        src = 15'h0000;
        repeat (4) @(negedge clk);
        dev = 1'b1;
        src[13] = 1'b1;
        up(r);
        src[13] = 1'b0;
        rdc(3'h7, 3'h0, 8'h88);
        rdc(3'h7, 3'h2, 8'h10);
        drain();
    endtask

    task automatic t_rail;
        int r;
        r = rises;
        src[9] = 1'b1;
        repeat (20) @(negedge clk);
        chk_in("rail off", r, r, rises);
        ra_on = 1'b1;
        ra_sw = 1'b1;
        @(negedge clk);
        ra_sw = 1'b0;
        up(r);
        rdc(3'h7, 3'h2, 8'h01);
        rdc(3'h7, 3'h0, 8'h80);
        wait_oe(1'b0, TO + 4);
        rdc(3'h7, 3'h2, 8'h01);
        repeat (TO + 8) @(negedge clk);
        src[9] = 1'b0;
        up(r);
        rdc(3'h7, 3'h2, 8'h00);
        drain();
        r = rises;
        rb_on = 1'b0;
        src[10] = 1'b1;
        repeat (20) @(negedge clk);
        chk_in("rail b off", r, r, rises);
        src[10] = 1'b0;
        repeat (4) @(negedge clk);
        rb_on = 1'b1;
        rb_sw = 1'b1;
        @(negedge clk);
        rb_sw = 1'b0;
        up(r);
        rdc(3'h7, 3'h2, 8'h02);
        rdc(3'h7, 3'h2, 8'h00);
        drain();
    endtask

    initial begin
        {rstn, ra_on, ra_sw, dev, rdone, mwr, ron, cfg_low} = 8'h00;
        act = 1'b1;
        rb_on = 1'b1;
        rb_sw = 1'b0;
        src = 15'h0000;
        mwd = 15'h0000;
        errors = 0;
        samples_checked = 0;
        cyc = 0;
        rises = 0;
        repeat (2) @(negedge clk);
        rstn = 1'b1;
        t_cfg();
        t_wake();
        t_timeout();
        t_multi();
        t_mask();
        t_rail();
        give_verdict();
    end
endmodule
